// ### core/vrps_pkg.sv
// Constants shared by the vibration report and power sequencing block
package vrps_pkg;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned BAUD_DEFAULT = 460800;
   // Rounded to nearest: truncation would leave the default rate over 3 % fast
   localparam logic [15:0] BAUD_DIV_DEFAULT = 16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
   localparam int unsigned SETTLE_MS = 30;
   localparam logic [31:0] SETTLE_CYCLES = 32'(CLK_HZ / 1000 * SETTLE_MS);
   localparam logic [7:0] ADV_LEN_BYTE = 8'h1B;
   localparam logic [7:0] ADV_TYPE_BYTE = 8'hFF;
   localparam int unsigned ADV_BYTES = 28;
   localparam int unsigned GROUP_BYTES = 8;
   localparam int unsigned X_GROUP_BASE = 4;
   localparam int unsigned Y_GROUP_BASE = 12;
   localparam int unsigned Z_GROUP_BASE = 20;
   localparam int unsigned IDX_UPPER_BITS = 5;
   localparam int unsigned FFT_N = 1024;
   localparam int unsigned NUM_BINS = FFT_N / 2;
   localparam logic [15:0] FS_DEFAULT_HZ = 16'h5DC0;
   localparam logic [2:0] LEN_CODE_DEFAULT = 3'h5;
   localparam logic [7:0] ASCII_COMMA = 8'h2C;
   localparam logic [7:0] ASCII_CR = 8'h0D;
   localparam logic [7:0] ASCII_LF = 8'h0A;
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_A = 8'h41;
   localparam logic [9:0] BIN_FIRST_AC = 10'h001;
endpackage

// ### core/vrps_skid.sv
`timescale 1ns/1ps
`default_nettype none
// Two-entry byte buffer between the framer and the serial shifter
module vrps_skid (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Fill side
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [7:0] o_data,
   input wire logic i_ready
);
   logic [7:0] mem_reg [2];
   logic wptr_reg;
   logic rptr_reg;
   logic [1:0] count_reg;
   wire push = i_valid && o_ready;
   wire pop = o_valid && i_ready;
   assign o_ready = (count_reg != 2'h2);
   assign o_valid = (count_reg != 2'h0);
   assign o_data = mem_reg[rptr_reg];
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mem_reg[0] <= 8'h00;
         mem_reg[1] <= 8'h00;
         wptr_reg <= 1'b0;
         rptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            mem_reg[wptr_reg] <= i_data;
            wptr_reg <= ~wptr_reg;
         end
         if (pop)
            rptr_reg <= ~rptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
   a_skid_no_overflow: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      count_reg <= 2'h2) else $error("buffer count above two");
   a_skid_hold_data: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_valid && !i_ready) |=> o_valid && $stable(o_data))
      else $error("buffered byte lost in stall");
endmodule
`default_nettype wire

// ### core/vrps_top.sv
`timescale 1ns/1ps
`default_nettype none
// Vibration report framer, serial text stream and sensor power sequencer
module vrps_top #(
   parameter logic [31:0] SETTLE_COUNT = vrps_pkg::SETTLE_CYCLES,
   parameter logic [7:0] ID_CHAR0 = 8'h51, // Arbitrary identity value
   parameter logic [7:0] ID_CHAR1 = 8'h52 // Arbitrary identity value
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Configuration
   input wire logic [15:0] i_baud_div,
   input wire logic i_serial_mode,
   input wire logic [7:0] i_interval_hours,
   input wire logic [7:0] i_interval_minutes,
   input wire logic i_interval_load,
   input wire logic [15:0] i_sample_freq_hz,
   input wire logic [2:0] i_len_code,
   // Real-time clock
   input wire logic i_rtc_match,
   output logic o_rtc_load,
   output logic [7:0] o_rtc_hours,
   output logic [7:0] o_rtc_minutes,
   // Sampling and spectrum results
   output logic o_sample_start,
   input wire logic i_sample_done,
   input wire logic i_bin_valid,
   input wire logic [1:0] i_bin_axis,
   input wire logic [9:0] i_bin_index,
   input wire logic [31:0] i_bin_energy,
   output logic o_bin_ready,
   input wire logic i_spectrum_done,
   // Power pins
   output logic o_supply_switch_enable_pin,
   output logic o_accel_output_enable_pin,
   output logic o_deep_sleep_state,
   output logic o_light_sleep_state,
   // Serial link
   output logic o_uart_tx,
   // Advertising and connected download
   input wire logic i_central_connected,
   output logic o_adv_valid,
   output logic [7:0] o_adv_data,
   output logic o_adv_last,
   input wire logic i_adv_ready,
   output logic o_dl_valid,
   output logic [1:0] o_dl_axis,
   output logic [9:0] o_dl_index,
   output logic [31:0] o_dl_energy,
   input wire logic i_dl_ready
);
   typedef enum {VRPS_DEEP, VRPS_SETTLE, VRPS_SAMPLE, VRPS_REPORT} vrps_pwr_t;
   vrps_pwr_t pwr_reg;
   logic [31:0] timer_reg;
   logic [15:0] peak_idx_reg [3];
   logic [31:0] peak_val_reg [3];
   logic [2:0] peak_seen_reg;
   logic [4:0] adv_ptr_reg;
   logic [7:0] adv_byte;
   // Sensor power sequencing
   wire timer_done = (timer_reg == 32'h0);
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pwr_reg <= VRPS_DEEP;
         timer_reg <= 32'h0;
      end else begin
         case (pwr_reg)
            VRPS_DEEP: if (i_rtc_match) begin
               pwr_reg <= VRPS_SETTLE;
               timer_reg <= SETTLE_COUNT - 32'h1;
            end
            VRPS_SETTLE: if (timer_done)
               pwr_reg <= VRPS_SAMPLE;
            else
               timer_reg <= timer_reg - 32'h1;
            VRPS_SAMPLE: if (i_sample_done)
               pwr_reg <= VRPS_REPORT;
            VRPS_REPORT: if (i_spectrum_done)
               pwr_reg <= VRPS_DEEP;
            default: pwr_reg <= VRPS_DEEP;
         endcase
      end
   end
   assign o_supply_switch_enable_pin = (pwr_reg == VRPS_SETTLE) ||
      (pwr_reg == VRPS_SAMPLE);
   assign o_accel_output_enable_pin = (pwr_reg == VRPS_SAMPLE);
   assign o_light_sleep_state = (pwr_reg == VRPS_SETTLE);
   assign o_deep_sleep_state = (pwr_reg == VRPS_DEEP);
   assign o_sample_start = (pwr_reg == VRPS_SETTLE) && timer_done;
   // Interval goes straight to the RTC, which owns the time keeping
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rtc_load <= 1'b0;
         o_rtc_hours <= 8'h00;
         o_rtc_minutes <= 8'h00;
      end else begin
         o_rtc_load <= i_interval_load;
         if (i_interval_load) begin
            o_rtc_hours <= i_interval_hours;
            o_rtc_minutes <= i_interval_minutes;
         end
      end
   end
   // Peak search over every bin from index 1 up, DC skipped; energy arrives already as float bits
   wire bin_take = i_bin_valid && o_bin_ready;
   wire bin_ac = (i_bin_index >= vrps_pkg::BIN_FIRST_AC);
   // Positive floats compare in order as unsigned integers
   genvar ax;
   generate
      for (ax = 0; ax < 3; ax++) begin : g_peak
         wire hit = bin_take && bin_ac && (i_bin_axis == 2'(ax)) &&
            (!peak_seen_reg[ax] || (i_bin_energy > peak_val_reg[ax]));
         always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               peak_idx_reg[ax] <= 16'h0;
               peak_val_reg[ax] <= 32'h0;
               peak_seen_reg[ax] <= 1'b0;
            end else if (o_sample_start) begin
               peak_seen_reg[ax] <= 1'b0;
            end else if (hit) begin
               peak_idx_reg[ax] <= {6'h00, i_bin_index};
               peak_val_reg[ax] <= i_bin_energy;
               peak_seen_reg[ax] <= 1'b1;
            end
         end
      end
   endgenerate
   // Advertising payload build
   wire [4:0] z_base = 5'(vrps_pkg::Z_GROUP_BASE);
   wire [4:0] y_base = 5'(vrps_pkg::Y_GROUP_BASE);
   wire [4:0] x_base = 5'(vrps_pkg::X_GROUP_BASE);
   wire in_z = (adv_ptr_reg >= z_base);
   wire in_y = (adv_ptr_reg >= y_base);
   wire [4:0] grp_off = in_z ? adv_ptr_reg - z_base :
      (in_y ? adv_ptr_reg - y_base : adv_ptr_reg - x_base);
   wire [1:0] grp_ax = in_z ? 2'd2 : (in_y ? 2'd1 : 2'd0);
   wire [15:0] g_idx = peak_idx_reg[grp_ax];
   wire [31:0] g_val = peak_val_reg[grp_ax];
   always_comb begin
      case (adv_ptr_reg)
         5'd0: adv_byte = vrps_pkg::ADV_LEN_BYTE;
         5'd1: adv_byte = vrps_pkg::ADV_TYPE_BYTE;
         5'd2: adv_byte = ID_CHAR0;
         5'd3: adv_byte = ID_CHAR1;
         default: begin
            case (grp_off[2:0])
               3'd0: adv_byte = {i_len_code, g_idx[12:8]};
               3'd1: adv_byte = g_idx[7:0];
               3'd2: adv_byte = i_sample_freq_hz[15:8];
               3'd3: adv_byte = i_sample_freq_hz[7:0];
               3'd4: adv_byte = g_val[7:0];
               3'd5: adv_byte = g_val[15:8];
               3'd6: adv_byte = g_val[23:16];
               default: adv_byte = g_val[31:24];
            endcase
         end
      endcase
   end
   wire adv_en = !i_central_connected && !i_serial_mode;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         adv_ptr_reg <= 5'd0;
      end else if (!adv_en) begin
         adv_ptr_reg <= 5'd0;
      end else if (i_adv_ready) begin
         adv_ptr_reg <= (adv_ptr_reg == 5'(vrps_pkg::ADV_BYTES - 1)) ? 5'd0 :
            adv_ptr_reg + 5'd1;
      end
   end
   assign o_adv_valid = adv_en;
   assign o_adv_data = adv_byte;
   assign o_adv_last = (adv_ptr_reg == 5'(vrps_pkg::ADV_BYTES - 1));
   // Connected download passes every bin through, DC included
   wire dl_mode = i_central_connected && !i_serial_mode;
   assign o_dl_valid = dl_mode && i_bin_valid;
   assign o_dl_axis = i_bin_axis;
   assign o_dl_index = i_bin_index;
   assign o_dl_energy = i_bin_energy;
   // CSV text: eight hex digits of each energy, comma between, CRLF after bin NUM_BINS - 1 whatever the axis
   logic [3:0] chr_reg;
   logic fb_ready;
   wire last_bin = (i_bin_index == 10'(vrps_pkg::NUM_BINS - 1));
   wire [3:0] nib = i_bin_energy[31 - 4 * chr_reg[2:0] -: 4];
   wire [7:0] hex_chr = (nib < 4'hA) ? vrps_pkg::ASCII_ZERO + {4'h0, nib} :
      vrps_pkg::ASCII_A + {4'h0, nib - 4'hA};
   wire [7:0] txt_chr = (chr_reg < 4'd8) ? hex_chr :
      (chr_reg == 4'd8) ? (last_bin ? vrps_pkg::ASCII_CR : vrps_pkg::ASCII_COMMA) :
      vrps_pkg::ASCII_LF;
   wire txt_end = (chr_reg == 4'd9) || ((chr_reg == 4'd8) && !last_bin);
   wire txt_valid = i_serial_mode && i_bin_valid;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n)
         chr_reg <= 4'd0;
      else if (txt_valid && fb_ready)
         chr_reg <= txt_end ? 4'd0 : chr_reg + 4'd1;
   end
   assign o_bin_ready = i_serial_mode ? (fb_ready && txt_end) :
      (i_central_connected ? i_dl_ready : 1'b1);
   // Byte buffer so a busy shifter stalls the text source without loss
   logic fb_valid;
   logic [7:0] fb_data;
   logic tx_take;
   vrps_skid u_skid (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_valid(txt_valid),
      .i_data(txt_chr),
      .o_ready(fb_ready),
      .o_valid(fb_valid),
      .o_data(fb_data),
      .i_ready(tx_take)
   );
   // 8-N-1 shifter: start, eight data LSB first, one stop, no parity
   logic [8:0] sh_reg;
   logic [3:0] bit_reg;
   logic [15:0] div_reg;
   logic busy_reg;
   wire [15:0] div_use = (i_baud_div == 16'h0) ? vrps_pkg::BAUD_DIV_DEFAULT :
      i_baud_div;
   wire bit_end = (div_reg == 16'h0);
   assign tx_take = !busy_reg;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sh_reg <= 9'h1FF;
         bit_reg <= 4'd0;
         div_reg <= 16'h0;
         busy_reg <= 1'b0;
      end else if (!busy_reg) begin
         if (fb_valid) begin
            sh_reg <= {fb_data, 1'b0};
            bit_reg <= 4'd9;
            div_reg <= div_use - 16'h1;
            busy_reg <= 1'b1;
         end
      end else if (bit_end) begin
         div_reg <= div_use - 16'h1;
         sh_reg <= {1'b1, sh_reg[8:1]};
         if (bit_reg == 4'd0)
            busy_reg <= 1'b0;
         bit_reg <= bit_reg - 4'd1;
      end else begin
         div_reg <= div_reg - 16'h1;
      end
   end
   assign o_uart_tx = sh_reg[0];
   // Independent count of light-sleep cycles, so a broken timer cannot hide itself
   logic [31:0] settle_seen_reg;
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n)
         settle_seen_reg <= 32'h0;
      else if (!o_light_sleep_state)
         settle_seen_reg <= 32'h0;
      else
         settle_seen_reg <= settle_seen_reg + 32'h1;
   end
   a_settle_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_sample_start |-> settle_seen_reg == SETTLE_COUNT - 32'h1)
      else $error("settle wait length wrong");
   a_peak_not_dc: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      peak_seen_reg[0] |-> peak_idx_reg[0] != 16'h0000)
      else $error("dc bin taken as peak");
   a_accel_while_ramp: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      o_light_sleep_state |-> !o_accel_output_enable_pin && o_supply_switch_enable_pin)
      else $error("accelerometer enabled during supply ramp");
   a_wake_powers_up: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_deep_sleep_state && i_rtc_match) |=> o_supply_switch_enable_pin)
      else $error("supply not switched on after wake");
   a_sample_off: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (pwr_reg == VRPS_SAMPLE && i_sample_done) |=> !o_supply_switch_enable_pin)
      else $error("supply left on after sampling");
   a_deep_stays: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_deep_sleep_state && !i_rtc_match) |=> o_deep_sleep_state)
      else $error("left deep sleep without match");
   a_adv_header: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_adv_valid && adv_ptr_reg == 5'd0) |-> o_adv_data == 8'h1B)
      else $error("advert first byte wrong");
   a_adv_second: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_adv_valid && adv_ptr_reg == 5'd1) |-> o_adv_data == 8'hFF)
      else $error("advert second byte wrong");
   a_adv_y_index: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_adv_valid && adv_ptr_reg == 5'd13) |-> o_adv_data == peak_idx_reg[1][7:0])
      else $error("y index byte misplaced");
   a_adv_z_freq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_adv_valid && adv_ptr_reg == 5'd22) |-> o_adv_data == i_sample_freq_hz[15:8])
      else $error("z frequency byte misplaced");
   a_adv_x_float: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (o_adv_valid && adv_ptr_reg == 5'd11) |-> o_adv_data == peak_val_reg[0][31:24])
      else $error("x float byte order wrong");
   a_uart_start: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (!busy_reg && fb_valid) |=> !o_uart_tx [*2])
      else $error("start bit too short");
endmodule
`default_nettype wire

// ### testbench/tb_vibration_report_and_power_seq.sv
// Self-checking bench for the vibration report and power sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_vibration_report_and_power_seq;
   typedef struct packed {logic [1:0] axis; logic [9:0] idx; logic [31:0] en;} vrps_bin_t;
   // Rows: each bin should leave the download side unchanged
   localparam vrps_bin_t ROWS [6] = '{
      '{2'h0, 10'h000, 32'h7F000000}, '{2'h0, 10'h001, 32'h3F800000},
      '{2'h0, 10'h1A3, 32'h40000000}, '{2'h1, 10'h002, 32'h41200000},
      '{2'h1, 10'h003, 32'h40A00000}, '{2'h2, 10'h1FF, 32'h3E000000}};
   // DC bin is the largest on purpose; it must not become the peak
   localparam logic [9:0] PK_IDX [3] = '{10'h1A3, 10'h002, 10'h1FF};
   localparam logic [31:0] PK_EN [3] = '{32'h40000000, 32'h41200000, 32'h3E000000};
   localparam logic [7:0] ID0 = 8'h51; // Arbitrary identity value
   localparam logic [7:0] ID1 = 8'h52; // Arbitrary identity value
   localparam logic [15:0] FS = 16'h5DC0;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_serial_mode, i_interval_load, i_rtc_match, i_sample_done, i_bin_valid;
   logic i_spectrum_done, i_central_connected, adv_en, i_adv_ready, i_dl_ready;
   logic [7:0] i_interval_hours, i_interval_minutes, o_rtc_hours, o_rtc_minutes, o_adv_data;
   logic [1:0] i_bin_axis, o_dl_axis;
   logic [9:0] i_bin_index, o_dl_index;
   logic [31:0] i_bin_energy, o_dl_energy;
   logic o_rtc_load, o_sample_start, o_bin_ready, o_supply_switch_enable_pin;
   logic o_accel_output_enable_pin, o_deep_sleep_state, o_light_sleep_state;
   logic o_uart_tx, o_adv_valid, o_adv_last, o_dl_valid;
   logic [7:0] exp_ser [$];
   logic [15:0] baud_div = 16'h0004;
   logic [15:0] host_div = 16'h0004;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #50 i_clock = !i_clock;
   vrps_top #(.SETTLE_COUNT(32'h00000032), .ID_CHAR0(ID0), .ID_CHAR1(ID1)) dut (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_baud_div(baud_div),
      .i_serial_mode(i_serial_mode), .i_interval_hours(i_interval_hours),
      .i_interval_minutes(i_interval_minutes), .i_interval_load(i_interval_load),
      .i_sample_freq_hz(FS), .i_len_code(3'h5), .i_rtc_match(i_rtc_match),
      .o_rtc_load(o_rtc_load), .o_rtc_hours(o_rtc_hours), .o_rtc_minutes(o_rtc_minutes),
      .o_sample_start(o_sample_start), .i_sample_done(i_sample_done),
      .i_bin_valid(i_bin_valid), .i_bin_axis(i_bin_axis), .i_bin_index(i_bin_index),
      .i_bin_energy(i_bin_energy), .o_bin_ready(o_bin_ready),
      .i_spectrum_done(i_spectrum_done),
      .o_supply_switch_enable_pin(o_supply_switch_enable_pin),
      .o_accel_output_enable_pin(o_accel_output_enable_pin),
      .o_deep_sleep_state(o_deep_sleep_state), .o_light_sleep_state(o_light_sleep_state),
      .o_uart_tx(o_uart_tx), .i_central_connected(i_central_connected),
      .o_adv_valid(o_adv_valid), .o_adv_data(o_adv_data), .o_adv_last(o_adv_last),
      .i_adv_ready(i_adv_ready), .o_dl_valid(o_dl_valid), .o_dl_axis(o_dl_axis),
      .o_dl_index(o_dl_index), .o_dl_energy(o_dl_energy), .i_dl_ready(i_dl_ready));
   vrps_host_model host (
      .i_clock(i_clock), .i_rst_n(i_rst_n), .i_uart_tx(o_uart_tx), .i_div(host_div),
      .i_adv_en(adv_en), .i_adv_valid(o_adv_valid), .i_adv_data(o_adv_data),
      .i_adv_last(o_adv_last), .o_adv_ready(i_adv_ready), .o_dl_ready(i_dl_ready));
   task automatic end_sim();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic void add_hex(input logic [31:0] v);
      for (int d = 7; d >= 0; d--) begin
         if (v[4*d+:4] < 4'hA) exp_ser.push_back(vrps_pkg::ASCII_ZERO + 8'(v[4*d+:4]));
         else exp_ser.push_back(vrps_pkg::ASCII_A + 8'(v[4*d+:4]) - 8'h0A);
      end
   endfunction
   // Called at a falling edge; leaves valid high so rows can run back to back
   task automatic send_bin(input vrps_bin_t r);
      int n;
      n = 0;
      i_bin_valid = 1'b1;
      {i_bin_axis, i_bin_index, i_bin_energy} = r;
      #1;
      while (o_bin_ready !== 1'b1 && n < 2000) begin
         @(negedge i_clock);
         #1;
         n++;
      end
      if (i_central_connected) chk({o_bin_ready, o_dl_valid, o_dl_axis, o_dl_index, o_dl_energy}, {i_dl_ready, 1'b1, r});
      @(negedge i_clock);
   endtask
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      logic [7:0] exp_adv [28];
      int n;
      logic early;
      {i_serial_mode, i_interval_load, i_rtc_match, i_sample_done, i_bin_valid} = '0;
      {i_spectrum_done, i_central_connected, adv_en} = '0;
      {i_interval_hours, i_interval_minutes} = 16'h0319;
      {i_bin_axis, i_bin_index, i_bin_energy} = '0;
      repeat (2) @(negedge i_clock);
      chk({o_supply_switch_enable_pin, o_accel_output_enable_pin}, 2'h0);
      chk({o_deep_sleep_state, o_uart_tx}, 2'h3);
      i_rst_n = 1'b1;
      @(negedge i_clock);
      i_interval_load = 1'b1;
      @(negedge i_clock);
      i_interval_load = 1'b0;
      chk({o_rtc_load, o_rtc_hours, o_rtc_minutes}, {1'b1, 16'h0319});
      @(negedge i_clock);
      chk(o_rtc_load, 1'b0);
      chk({o_deep_sleep_state, o_supply_switch_enable_pin}, 2'h2);
      i_rtc_match = 1'b1;
      @(negedge i_clock);
      i_rtc_match = 1'b0;
      chk({o_supply_switch_enable_pin, o_light_sleep_state, o_deep_sleep_state}, 3'h6);
      n = 0;
      early = 1'b0;
      // A second match while settling must be ignored
      while (o_sample_start !== 1'b1 && n < 1000) begin
         early = early | (o_accel_output_enable_pin !== 1'b0);
         i_rtc_match = (n == 10);
         @(negedge i_clock);
         n++;
      end
      chk(early, 1'b0);
      chk(n, 49);
      @(negedge i_clock);
      chk({o_accel_output_enable_pin, o_supply_switch_enable_pin, o_light_sleep_state}, 3'h6);
      i_sample_done = 1'b1;
      @(negedge i_clock);
      i_sample_done = 1'b0;
      chk({o_supply_switch_enable_pin, o_accel_output_enable_pin}, 2'h0);
      i_central_connected = 1'b1;
      foreach (ROWS[k]) send_bin(ROWS[k]);
      i_bin_valid = 1'b0;
      i_central_connected = 1'b0;
      adv_en = 1'b1;
      n = 0;
      while (host.adv_q.size() < 28 && n < 500) begin
         @(negedge i_clock);
         n++;
      end
      adv_en = 1'b0;
      exp_adv[0] = vrps_pkg::ADV_LEN_BYTE;
      exp_adv[1] = vrps_pkg::ADV_TYPE_BYTE;
      exp_adv[2] = ID0;
      exp_adv[3] = ID1;
      for (int a = 0; a < 3; a++) begin
         exp_adv[4+8*a] = {3'h5, 3'h0, PK_IDX[a][9:8]};
         exp_adv[5+8*a] = PK_IDX[a][7:0];
         exp_adv[6+8*a] = FS[15:8];
         exp_adv[7+8*a] = FS[7:0];
         for (int b = 0; b < 4; b++) exp_adv[8+8*a+b] = PK_EN[a][8*b+:8];
      end
      for (int i = 0; i < 28; i++) chk(host.adv_q[i], {1'(i == 27), exp_adv[i]});
      // Serial text: a comma after each value except the last bin, which gets the line end instead
      i_serial_mode = 1'b1;
      add_hex(ROWS[1].en);
      exp_ser.push_back(vrps_pkg::ASCII_COMMA);
      add_hex(ROWS[5].en);
      exp_ser.push_back(vrps_pkg::ASCII_CR);
      exp_ser.push_back(vrps_pkg::ASCII_LF);
      send_bin(ROWS[1]);
      send_bin(ROWS[5]);
      i_bin_valid = 1'b0;
      n = 0;
      while (host.rx_q.size() < exp_ser.size() && n < 3000) begin
         @(negedge i_clock);
         n++;
      end
      chk(o_adv_valid, 1'b0);
      // A zero divider selects the default rate; switched only while the line is idle
      baud_div = 16'h0000;
      host_div = vrps_pkg::BAUD_DIV_DEFAULT;
      add_hex(ROWS[2].en);
      exp_ser.push_back(vrps_pkg::ASCII_COMMA);
      send_bin(ROWS[2]);
      i_bin_valid = 1'b0;
      n = 0;
      while (host.rx_q.size() < exp_ser.size() && n < 3000) begin
         @(negedge i_clock);
         n++;
      end
      foreach (exp_ser[k]) chk(host.rx_q[k], exp_ser[k]);
      chk(host.frame_errors, 0);
      i_spectrum_done = 1'b1;
      @(negedge i_clock);
      i_spectrum_done = 1'b0;
      @(negedge i_clock);
      chk({o_deep_sleep_state, o_supply_switch_enable_pin}, 2'h2);
      end_sim();
   end
endmodule
`default_nettype wire

// ### testbench/vrps_host_model.sv
// Far side model: serial console receiver and wireless central reader
`timescale 1ns/1ps
`default_nettype none
module vrps_host_model (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // Serial line
   input wire logic i_uart_tx,
   input wire logic [15:0] i_div,
   // Central side
   input wire logic i_adv_en,
   input wire logic i_adv_valid,
   input wire logic [7:0] i_adv_data,
   input wire logic i_adv_last,
   output logic o_adv_ready,
   output logic o_dl_ready
);
   logic [7:0] rx_q [$];
   logic [8:0] adv_q [$];
   int frame_errors = 0;
   logic stall_reg = 1'b0;
   // Ready every other cycle, so the block always meets a stalling reader
   always @(negedge i_clock) stall_reg <= !stall_reg;
   assign o_adv_ready = i_adv_en && stall_reg;
   assign o_dl_ready = stall_reg;
   always @(posedge i_clock) begin
      if (i_rst_n && o_adv_ready && i_adv_valid) adv_q.push_back({i_adv_last, i_adv_data});
   end
   // Sampled mid-bit, LSB first, one stop bit
   always begin : rx
      logic [7:0] b;
      @(negedge i_uart_tx);
      repeat (i_div / 2) @(posedge i_clock);
      for (int k = 0; k < 8; k++) begin
         repeat (i_div) @(posedge i_clock);
         b[k] = i_uart_tx;
      end
      repeat (i_div) @(posedge i_clock);
      if (i_uart_tx !== 1'b1) frame_errors++;
      rx_q.push_back(b);
   end
endmodule
`default_nettype wire
